/* File: lcdc_ctrl.sv */
// What this block does
// RULE1 - Supply bit on enables generator; off grounds drives
// RULE2 - Software waits about 100 ms after enabling
// RULE3 - Supply bit leaves DC-output segment pins alone
// RULE4 - Duty field picks 1/4, 1/5, 1/6, 1/3
// RULE5 - Static bit selects static, else multiplexed drive
// RULE6 - All-on lights every segment, memory kept
// RULE7 - All-off blanks every segment, memory kept
// RULE8 - All-on wins when both force bits set
// RULE9 - Contrast field: sixteen steps, zero lightest
// RULE10 - External drive supply makes contrast ineffective
// RULE11 - Reset clears contrast field to zero
// RULE12 - Reset sets all-off, display starts blank
// RULE13 - Reset clears supply, duty, static, all-on
// RULE14 - Unimplemented bits read zero, ignore writes
// RULE15 - Software initialises memory, contrast, enables display
//
// The implementer's own choice: the plain strobed port.
`include "lcdc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module lcdc_ctrl #(
  parameter int          SLOT_CYCLES = `LCDC_SLOT_CYCLES,
  parameter bit          EXT_SUPPLY  = 1'b0,
  parameter logic [31:0] SEG_DC_MASK = 32'h0000_0000
) (
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst_b,
  input  wire lcdc_pkg::lcdc_bus_s i_bus,
  output logic [3:0]              o_rdata,
  input  wire logic [31:0]        i_disp_row,
  input  wire logic [31:0]        i_dc_level,
  output logic [2:0]              o_scan_com,
  output lcdc_pkg::lcdc_drive_s   o_drive
);
  import lcdc_pkg::*;

  // Commons in use for a duty code
  function automatic logic [2:0] com_count(input lcdc_duty_e d);
    case (d)
      LCDC_DUTY_4: com_count = 3'h4;
      LCDC_DUTY_5: com_count = 3'h5;
      LCDC_DUTY_6: com_count = 3'h6;
      LCDC_DUTY_3: com_count = 3'h3;
      default:     com_count = 3'h4;
    endcase
  endfunction

  function automatic logic [5:0] com_onehot(input logic [2:0] idx);
    com_onehot = 6'h01 << idx;
  endfunction

  localparam logic [31:0] SLOT_LAST = 32'(SLOT_CYCLES - 1);

  // Control registers
  logic        supply_on;
  logic        static_sel;
  lcdc_duty_e  duty;
  logic        all_on;
  logic        all_off;
  logic [3:0]  contrast;

  // Scan state
  lcdc_state_e state;
  lcdc_state_e next_state;
  logic [31:0] slot_cnt;
  logic [2:0]  com_idx;
  logic        frame_pol;

  // Bus decode
  wire hit_drive    = (i_bus.addr == `LCDC_ADDR_DRIVE);
  wire hit_force    = (i_bus.addr == `LCDC_ADDR_FORCE);
  wire hit_contrast = (i_bus.addr == `LCDC_ADDR_CONTRAST);
  wire wr_drive     = i_bus.wr & hit_drive;
  wire wr_force     = i_bus.wr & hit_force;
  wire wr_contrast  = i_bus.wr & hit_contrast;

  wire [3:0] rd_drive = {duty, static_sel, supply_on};
  // Bits 3 and 0 of the force register have no storage
  wire [3:0] rd_force = {1'b0, all_off, all_on, 1'b0}; // RULE14
  wire [3:0] next_rdata = !i_bus.rd    ? 4'h0 :
                          hit_drive    ? rd_drive :
                          hit_force    ? rd_force :
                          hit_contrast ? contrast : 4'h0;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      supply_on  <= 1'b0; // RULE13
      static_sel <= 1'b0; // RULE13
      duty       <= LCDC_DUTY_4; // RULE13
      all_on     <= `LCDC_RST_ALL_ON; // RULE13
      all_off    <= `LCDC_RST_ALL_OFF; // RULE12
      contrast   <= `LCDC_RST_CONTRAST; // RULE11
    end else begin
      if (wr_drive) begin
        supply_on  <= i_bus.wdata[`LCDC_BIT_SUPPLY];
        static_sel <= i_bus.wdata[`LCDC_BIT_STATIC];
        duty       <= lcdc_duty_e'(i_bus.wdata[`LCDC_BIT_DUTY_HI:`LCDC_BIT_DUTY_LO]);
      end
      if (wr_force) begin
        all_on  <= i_bus.wdata[`LCDC_BIT_ALL_ON]; // RULE14
        all_off <= i_bus.wdata[`LCDC_BIT_ALL_OFF];
      end
      if (wr_contrast) begin
        contrast <= i_bus.wdata; // RULE9
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_rdata <= 4'h0;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  // Scan sequencing
  wire [2:0] ncom      = com_count(duty);
  wire       slot_end  = (slot_cnt >= SLOT_LAST);
  wire       last_com  = (com_idx >= ncom - 3'h1);

  always_comb begin
    case (state)
      LCDC_ST_BLANK:  next_state = !supply_on ? LCDC_ST_BLANK :
                                   static_sel ? LCDC_ST_STATIC : LCDC_ST_SCAN;
      LCDC_ST_SCAN:   next_state = !supply_on ? LCDC_ST_BLANK :
                                   static_sel ? LCDC_ST_STATIC : LCDC_ST_SCAN; // RULE5
      LCDC_ST_STATIC: next_state = !supply_on ? LCDC_ST_BLANK :
                                   static_sel ? LCDC_ST_STATIC : LCDC_ST_SCAN; // RULE5
      default:        next_state = LCDC_ST_BLANK;
    endcase
  end

  // A mode change, or a duty change that leaves the current common past the
  // new last common, restarts the scan at common 0 rather than running on
  wire restart = (state != next_state) || (com_idx >= ncom);

  wire [2:0] next_com_idx = (restart || next_state != LCDC_ST_SCAN) ? 3'h0 :
                            !slot_end ? com_idx :
                            last_com  ? 3'h0 : 3'(com_idx + 3'h1); // RULE4

  // Polarity flips every frame in scan, every slot in static drive
  wire next_pol = (restart || next_state == LCDC_ST_BLANK) ? 1'b0 :
                  !slot_end ? frame_pol :
                  (state == LCDC_ST_STATIC || last_com) ? ~frame_pol : frame_pol;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      state     <= LCDC_ST_BLANK;
      slot_cnt  <= 32'h0;
      com_idx   <= 3'h0;
      frame_pol <= 1'b0;
    end else begin
      state     <= next_state;
      slot_cnt  <= (restart || slot_end) ? 32'h0 : slot_cnt + 32'h1;
      com_idx   <= next_com_idx;
      frame_pol <= next_pol;
    end
  end

  // Segment decision; force bits bypass the row data so memory stays intact
  wire [31:0] lcd_lit = all_on  ? 32'hffff_ffff : // RULE6 RULE8
                        all_off ? 32'h0000_0000 : // RULE7
                        i_disp_row;
  wire        driving = (state != LCDC_ST_BLANK) && supply_on;
  wire [31:0] lcd_part = driving ? (lcd_lit & ~SEG_DC_MASK) : 32'h0; // RULE1
  wire [31:0] next_seg = lcd_part | (i_dc_level & SEG_DC_MASK); // RULE3

  wire [5:0]  next_com = !driving ? 6'h00 : com_onehot(com_idx); // RULE1 RULE4

  // External supply leaves the regulator code unused
  wire [3:0]  next_contrast = EXT_SUPPLY ? 4'h0 : contrast; // RULE10

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_drive    <= '0;
      o_scan_com <= 3'h0;
    end else begin
      o_drive.vgen_en   <= supply_on; // RULE1
      o_drive.contrast  <= next_contrast;
      o_drive.com_sel   <= next_com;
      o_drive.frame_pol <= frame_pol;
      o_drive.seg_lit   <= next_seg;
      o_scan_com        <= next_com_idx;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  // Steady multiplexed scan with no restart pending this cycle
  wire scan_steady = (state == LCDC_ST_SCAN) && (next_state == LCDC_ST_SCAN) && !restart;

  sequence s_rd_force;
    i_bus.rd && hit_force;
  endsequence

  sequence s_wr_static;
    wr_drive && i_bus.wdata[`LCDC_BIT_SUPPLY] && i_bus.wdata[`LCDC_BIT_STATIC];
  endsequence

  sequence s_slot_hold;
    scan_steady && !slot_end;
  endsequence

  sequence s_slot_step;
    scan_steady && slot_end && !last_com;
  endsequence

  sequence s_slot_wrap;
    scan_steady && slot_end && last_com;
  endsequence

  a_supply_off_ground: assert property ( // RULE1
    !supply_on |=> !o_drive.vgen_en && o_drive.com_sel == 6'h00
                   && (o_drive.seg_lit & ~SEG_DC_MASK) == 32'h0)
    else $error("drive active while supply off");

  a_dc_pins_kept: assert property ( // RULE3
    i_rst_b |=> (o_drive.seg_lit & SEG_DC_MASK) == ($past(i_dc_level) & SEG_DC_MASK))
    else $error("dc segment pin altered");

  a_duty_com_range: assert property ( // RULE4
    state == LCDC_ST_SCAN && !wr_drive |=> o_scan_com < ncom)
    else $error("common index beyond duty");

  a_static_one_com: assert property ( // RULE5
    s_wr_static ##1 1'b1 ##1 1'b1 |-> state == LCDC_ST_STATIC ##1 o_drive.com_sel == 6'h01)
    else $error("static drive not entered");

  a_all_on_lit: assert property ( // RULE6
    driving && all_on |=> (o_drive.seg_lit & ~SEG_DC_MASK) == ~SEG_DC_MASK)
    else $error("all-on segments not lit");

  a_all_off_dark: assert property ( // RULE7
    all_off && !all_on |=> (o_drive.seg_lit & ~SEG_DC_MASK) == 32'h0)
    else $error("all-off segments lit");

  a_force_priority: assert property ( // RULE8
    wr_force && i_bus.wdata[`LCDC_BIT_ALL_ON] && i_bus.wdata[`LCDC_BIT_ALL_OFF] && supply_on
    && state != LCDC_ST_BLANK ##1 driving |=> (o_drive.seg_lit & ~SEG_DC_MASK) == ~SEG_DC_MASK)
    else $error("all-off beat all-on");

  a_contrast_out: assert property ( // RULE9
    wr_contrast |=> ##1 o_drive.contrast == (EXT_SUPPLY ? 4'h0 : $past(i_bus.wdata, 2)))
    else $error("contrast code not applied");

  a_reset_values: assert property (@(posedge i_ref_clk) disable iff (1'b0) // RULE11 RULE12 RULE13
    !i_rst_b |=> contrast == 4'h0 && all_off && !all_on && !supply_on
                 && !static_sel && duty == LCDC_DUTY_4 && o_rdata == 4'h0)
    else $error("bad reset value");

  a_unused_bits_zero: assert property ( // RULE14
    s_rd_force |=> o_rdata[3] == 1'b0 && o_rdata[0] == 1'b0 && o_rdata[2] == all_off)
    else $error("unused force bits read nonzero");

  a_com_onehot: assert property ( // RULE4
    driving |=> $onehot(o_drive.com_sel))
    else $error("active common not one-hot");

  a_com_advance: assert property ( // RULE4
    s_slot_step |=> o_scan_com == 3'($past(o_scan_com) + 3'h1))
    else $error("common did not advance at slot end");

  a_com_wrap: assert property ( // RULE4
    s_slot_wrap |=> o_scan_com == 3'h0)
    else $error("scan did not wrap to common 0");

  a_com_hold: assert property ( // RULE4
    s_slot_hold |=> $stable(o_scan_com))
    else $error("common changed inside a slot");

  a_restart_at_zero: assert property ( // RULE4
    state != next_state |=> o_scan_com == 3'h0)
    else $error("mode change did not restart at common 0");

  a_frame_pol_flip: assert property ( // RULE4
    s_slot_wrap |=> ##1 o_drive.frame_pol != $past(o_drive.frame_pol))
    else $error("polarity kept across frame wrap");

  a_pol_hold: assert property ( // RULE4
    s_slot_hold |=> ##1 $stable(o_drive.frame_pol))
    else $error("polarity changed inside a slot");

  a_static_com_only: assert property ( // RULE5
    state == LCDC_ST_STATIC && supply_on |=> o_drive.com_sel == 6'h01)
    else $error("static drive used a second common");

  a_static_pol_slot: assert property ( // RULE5
    state == LCDC_ST_STATIC && next_state == LCDC_ST_STATIC && slot_end
    |=> ##1 o_drive.frame_pol != $past(o_drive.frame_pol))
    else $error("static polarity kept across slot");

  a_blank_no_com: assert property ( // RULE1
    state == LCDC_ST_BLANK |=> o_drive.com_sel == 6'h00)
    else $error("common active while blank");

  a_off_goes_blank: assert property ( // RULE1
    !supply_on |=> state == LCDC_ST_BLANK)
    else $error("scan kept running with supply off");

  a_vgen_follows: assert property ( // RULE1
    i_rst_b |=> o_drive.vgen_en == $past(supply_on))
    else $error("generator enable does not follow supply bit");

  a_seg_normal: assert property ( // RULE6 RULE7
    driving && !all_on && !all_off
    |=> (o_drive.seg_lit & ~SEG_DC_MASK) == ($past(i_disp_row) & ~SEG_DC_MASK))
    else $error("normal display not taken from memory row");

  a_force_stored: assert property ( // RULE6 RULE7
    wr_force |=> all_on == $past(i_bus.wdata[`LCDC_BIT_ALL_ON])
                 && all_off == $past(i_bus.wdata[`LCDC_BIT_ALL_OFF]))
    else $error("force bits not stored");

  a_contrast_hold: assert property ( // RULE9
    i_rst_b && !wr_contrast |=> $stable(contrast))
    else $error("contrast changed without a write");

  a_drive_hold: assert property ( // RULE1 RULE4 RULE5
    i_rst_b && !wr_drive |=> $stable(supply_on) && $stable(static_sel) && $stable(duty))
    else $error("drive control changed without a write");

  a_ext_contrast_zero: assert property ( // RULE10
    i_rst_b && EXT_SUPPLY |=> o_drive.contrast == 4'h0)
    else $error("contrast code used with external supply");

  a_rdata_idle_zero: assert property ( // RULE14
    i_rst_b && !i_bus.rd |=> o_rdata == 4'h0)
    else $error("read data outside a read cycle");

  a_rd_contrast: assert property ( // RULE9
    i_bus.rd && hit_contrast |=> o_rdata == $past(contrast))
    else $error("contrast read back wrong");

  a_rd_unmapped: assert property ( // RULE14
    i_bus.rd && !hit_drive && !hit_force && !hit_contrast |=> o_rdata == 4'h0)
    else $error("unmapped read nonzero");

  a_wr_unmapped: assert property ( // RULE14
    i_rst_b && i_bus.wr && !hit_drive && !hit_force && !hit_contrast
    |=> $stable(contrast) && $stable(all_on) && $stable(all_off) && $stable(supply_on))
    else $error("unmapped write changed a register");

endmodule
`default_nettype wire

/* File: lcdc_ctrl_test.sv */
`timescale 1ns/1ps
`default_nettype none
module lcdc_ctrl_test;
  import lcdc_pkg::*;
  localparam logic [31:0] DCM = 32'h0000_0003;
  localparam logic [31:0] DCL = 32'h0000_0002;
  localparam logic [31:0] ROW = 32'h5a5a_5a58;
  logic              i_ref_clk;
  logic              i_rst_b;
  lcdc_bus_s         bus;
  logic [3:0]        rdata;
  logic [31:0]       row;
  logic [31:0]       dcl;
  logic [2:0]        scan_com;
  lcdc_drive_s       drv;
  int                error_cnt;
  int                total_checks;
  logic [5:0]        seen;
  int                flips;
  logic [3:0]        rdata_ext;
  lcdc_drive_s       drv_ext;

  lcdc_ctrl #(.SLOT_CYCLES(4), .EXT_SUPPLY(1'b0), .SEG_DC_MASK(DCM)) dut (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_bus(bus), .o_rdata(rdata),
    .i_disp_row(row), .i_dc_level(dcl), .o_scan_com(scan_com), .o_drive(drv));
  lcdc_panel #(.ROW(ROW)) panel (.i_scan_com(scan_com), .o_row(row));
  // Same bus into a build whose drive supply comes from outside
  lcdc_ctrl #(.SLOT_CYCLES(4), .EXT_SUPPLY(1'b1), .SEG_DC_MASK(DCM)) dut_ext (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_bus(bus), .o_rdata(rdata_ext),
    .i_disp_row(row), .i_dc_level(dcl), .o_scan_com(), .o_drive(drv_ext));

  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [3:0] d);
    @(posedge i_ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_ref_clk);
    bus <= '0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [3:0] exp);
    @(posedge i_ref_clk);
    bus <= '{addr: a, wdata: 4'h0, wr: 1'b0, rd: 1'b1};
    @(posedge i_ref_clk);
    bus <= '0;
    #1;
    chk("rdata", {28'h0, exp}, {28'h0, rdata});
  endtask

  // Gather every common that goes active; long enough for two full 1/6 frames
  task automatic scan(input int n);
    logic pol;
    repeat (3) @(posedge i_ref_clk);
    #1;
    seen = 6'h00;
    flips = 0;
    pol = drv.frame_pol;
    repeat (n) begin
      @(posedge i_ref_clk);
      #1;
      seen = seen | drv.com_sel;
      if (drv.frame_pol !== pol) begin
        flips++;
      end
      pol = drv.frame_pol;
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #200us;
    error_cnt++;
    end_sim();
  end

  initial begin
    error_cnt = 0;
    total_checks = 0;
    bus = '0;
    i_rst_b = 1'b0;
    dcl = DCL;
    repeat (5) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    rd(16'hff60, 4'h0);
    rd(16'hff61, 4'h4);
    rd(16'hff62, 4'h0);
    chk("seg_off", DCL, drv.seg_lit);
    wr(16'hff63, 4'hf);
    rd(16'hff63, 4'h0);
    wr(16'hff61, 4'hf);
    rd(16'hff61, 4'h6);
    wr(16'hff62, 4'hf);
    rd(16'hff62, 4'hf);
    chk("ext_rdata", 32'hf, {28'h0, rdata_ext});
    chk("contrast", 32'hf, {28'h0, drv.contrast});
    chk("ext_contrast", 32'h0, {28'h0, drv_ext.contrast});
    wr(16'hff61, 4'h0);
    for (int d = 0; d < 4; d++) begin
      // Settle time is analog only; the logic needs no wait after enabling
      wr(16'hff60, {d[1:0], 2'b01});
      scan(56);
      chk("flips", 32'h1, {31'h0, flips >= 2});
      chk("vgen", 32'h1, {31'h0, drv.vgen_en});
      chk("commons", (d == 3) ? 32'h7 : (32'h1 << (d + 4)) - 32'h1, {26'h0, seen});
      chk("seg_row", (ROW & ~DCM) | DCL, drv.seg_lit);
    end
    wr(16'hff60, 4'h3);
    scan(24);
    chk("static", 32'h1, {26'h0, seen});
    chk("static_flips", 32'h1, {31'h0, flips >= 2});
    wr(16'hff61, 4'h2);
    scan(8);
    chk("all_on", ~DCM | DCL, drv.seg_lit);
    wr(16'hff61, 4'h6);
    scan(8);
    chk("both", ~DCM | DCL, drv.seg_lit);
    wr(16'hff61, 4'h4);
    scan(8);
    chk("all_off", DCL, drv.seg_lit);
    wr(16'hff61, 4'h0);
    scan(8);
    chk("resume", (ROW & ~DCM) | DCL, drv.seg_lit);
    wr(16'hff60, 4'h0);
    scan(8);
    chk("sup_off", 32'h0, {26'h0, seen});
    chk("dc_kept", DCL, drv.seg_lit);
    chk("vgen_off", 32'h0, {31'h0, drv.vgen_en});
    chk("pol_off", 32'h0, {31'h0, drv.frame_pol});
    end_sim();
  end
endmodule
`default_nettype wire

/* File: lcdc_panel.sv */
`timescale 1ns/1ps
`default_nettype none
module lcdc_panel #(
  parameter logic [31:0] ROW = 32'h5a5a_5a58
) (
  input  wire logic [2:0]  i_scan_com,
  output logic [31:0]      o_row
);
  // Same row for every common so the lit check does not depend on scan phase
  // Unused commons return the inverted row rather than a stale row
  assign o_row = (i_scan_com < 3'h6) ? ROW : ~ROW;
endmodule
`default_nettype wire

/* File: lcdc_pkg.sv */
`default_nettype none
package lcdc_pkg;

  typedef enum logic [1:0] {
    LCDC_DUTY_4 = 2'h0,
    LCDC_DUTY_5 = 2'h1,
    LCDC_DUTY_6 = 2'h2,
    LCDC_DUTY_3 = 2'h3
  } lcdc_duty_e;

  typedef enum logic [1:0] {
    LCDC_ST_BLANK  = 2'h0,
    LCDC_ST_SCAN   = 2'h1,
    LCDC_ST_STATIC = 2'h3
  } lcdc_state_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [3:0]  wdata;
    logic        wr;
    logic        rd;
  } lcdc_bus_s;

  typedef struct packed {
    logic        vgen_en;
    logic [3:0]  contrast;
    logic [5:0]  com_sel;
    logic        frame_pol;
    logic [31:0] seg_lit;
  } lcdc_drive_s;

endpackage
`default_nettype wire

/* File: lcdc_regs.svh */
`ifndef LCDC_REGS_SVH
`define LCDC_REGS_SVH

// Register byte addresses
`define LCDC_ADDR_DRIVE     16'hff60
`define LCDC_ADDR_FORCE     16'hff61
`define LCDC_ADDR_CONTRAST  16'hff62

// Drive control fields
`define LCDC_BIT_SUPPLY     0
`define LCDC_BIT_STATIC     1
`define LCDC_BIT_DUTY_LO    2
`define LCDC_BIT_DUTY_HI    3

// Force control fields
`define LCDC_BIT_ALL_ON     1
`define LCDC_BIT_ALL_OFF    2

// Reset values
`define LCDC_RST_DRIVE      4'h0
`define LCDC_RST_ALL_ON     1'b0
`define LCDC_RST_ALL_OFF    1'b1
`define LCDC_RST_CONTRAST   4'h0

// Timing
`define LCDC_CLK_HZ         50000000
`define LCDC_SLOT_US        1000
`define LCDC_SLOT_CYCLES    ((`LCDC_SLOT_US) * ((`LCDC_CLK_HZ) / 1000000))
`define LCDC_SETTLE_MS      100

`endif
